// ### hw/acso_pkg.sv
// Purpose: Shared constants for the channel sequencing and averaging control block.
// Assumes: System clock of 250 MHz.
// Notes: All timing counts derive from the rates named here.
package acso_pkg;

  // ----------------------------------------------------------------------
  // Ratio codes
  // ----------------------------------------------------------------------
  localparam logic [2:0] RATIO_NONE = 3'h0;
  localparam logic [2:0] RATIO_2 = 3'h1;
  localparam logic [2:0] RATIO_4 = 3'h2;
  localparam logic [2:0] RATIO_8 = 3'h3;
  localparam logic [2:0] RATIO_16 = 3'h4;
  localparam logic [2:0] RATIO_32 = 3'h5;
  localparam logic [2:0] RATIO_MAX_NORMAL = 3'h5;
  localparam logic [2:0] RATIO_MAX_ROLLING = 3'h3;

  // ----------------------------------------------------------------------
  // Mode and channel encodings
  // ----------------------------------------------------------------------
  localparam logic STYLE_NORMAL = 1'b0;
  localparam logic STYLE_ROLLING = 1'b1;
  localparam logic SET_INDEX0 = 1'b0;
  localparam logic SET_INDEX1 = 1'b1;

  // ----------------------------------------------------------------------
  // Widths and depths
  // ----------------------------------------------------------------------
  localparam int SAMPLE_W = 16;
  localparam int OUT_W = 16;
  localparam int BOOST_BITS = 2;
  localparam int HIST_DEPTH = 8;
  localparam logic [SAMPLE_W-1:0] SAMPLE_RESET = 16'h0000;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int PACE_HI_RES_KSPS = 3000;
  localparam int PACE_LO_RES_KSPS = 4000;
  // Longest spacing between internally paced samples rounds down.
  localparam int PACE_HI_RES_CYC = (CLK_MHZ * 1000) / PACE_HI_RES_KSPS;
  localparam int PACE_LO_RES_CYC = (CLK_MHZ * 1000) / PACE_LO_RES_KSPS;

endpackage : acso_pkg

// ### hw/acso_history.sv
// Purpose: Eight-deep sample history with a sum of the newest n entries.
// Assumes: Shift and fill pulses come from the same clock.
// Notes: Entry 0 is the newest sample.
`timescale 1ns/1ns
module acso_history #(
  parameter int W = acso_pkg::SAMPLE_W,
  parameter int DEPTH = acso_pkg::HIST_DEPTH
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Sample input
  input wire logic shift_i,
  input wire logic fill_i,
  input wire logic [W-1:0] sample_i,
  // Sum of the newest 2^log2n entries
  input wire logic [1:0] log2n_i,
  output logic [W+2:0] sum_o
);

  initial begin
    if (DEPTH != 8) $error("history depth must be 8");
  end

  logic [W-1:0] hist_q [DEPTH];
  logic [W-1:0] view [DEPTH];
  logic [W+2:0] part [DEPTH];

  always_ff @(posedge mclk_i) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (!rst_n_i) begin
        hist_q[i] <= '0;
      end else if (fill_i) begin
        hist_q[i] <= sample_i;
      end else if (shift_i) begin
        hist_q[i] <= (i == 0) ? sample_i : hist_q[(i == 0) ? 0 : i - 1];
      end
    end
  end

  // The sums see the entries as they stand after this cycle's shift or fill.
  // A result that arrives with its strobe is therefore counted in the average it closes.
  // Running prefix sums; part[k] holds the newest k+1 entries.
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_pref
      if (g == 0) begin : g_first
        assign view[g] = (fill_i || shift_i) ? sample_i : hist_q[g];
        assign part[g] = {3'h0, view[g]};
      end else begin : g_rest
        assign view[g] = fill_i ? sample_i : (shift_i ? hist_q[g-1] : hist_q[g]);
        assign part[g] = part[g-1] + {3'h0, view[g]};
      end
    end
  endgenerate

  wire logic [2:0] last_idx = 3'((4'h1 << log2n_i) - 4'h1);
  assign sum_o = part[last_idx];

endmodule : acso_history

// ### hw/acso_sync.sv
// Purpose: Two flip-flop synchroniser for a level from outside the clock domain.
// Assumes: Input changes slowly relative to mclk_i.
// Notes: The first stage feeds only the second.
`timescale 1ns/1ns
module acso_sync (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Level
  input wire logic async_i,
  output logic sync_o
);

  logic meta_q;
  logic sync_q;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule : acso_sync

// ### hw/acso_ctrl.sv
// Purpose: Channel set choice, conversion pacing and averaging of results.
// Assumes: Conversion results arrive with a done strobe on mclk_i.
// Notes: Chip select is a pin and is synchronised before use.
`timescale 1ns/1ns

// Notes on behaviour
// - Sequencer off: channel-set bit 0 picks index-0 inputs, 1 picks index-1.
// - Sequencer enable bit 0 disables sequencing, 1 enables it.
// - While sequencing, the manual channel-set bit is ignored.
// - Sequencer starts at index-0, then alternates every chip-select-started conversion; paced conversions keep the set.
// - Style bit 0 with valid nonzero ratio gives normal averaging.
// - Style bit 1 with valid nonzero ratio gives rolling averaging.
// - Normal ratio codes: 0 none, 1..5 give 2..32, 6 and 7 invalid.
// - Rolling ratio codes: 0 none, 1..3 give 2..8, 4 to 7 invalid.
// - Normal: chip select starts first conversion, device paces the rest, outputs mean.
// - Extra samples paced at 3 MSPS high-resolution, 4 MSPS otherwise.
// - Normal group result ready for next read; accumulator then cleared.
// - Averaged output is 16 bits unless resolution boost is set.
// - Normal averaging output rate falls by the ratio.
// - Rolling: every conversion host-started; each result enters history.
// - First conversion after any reset fills every history entry.
// - Every completed conversion shifts into history, whatever the settings.
// - Rolling output is mean of newest n history entries, one per conversion.
// - Boost with valid averaging widens result by two bits.
module acso_ctrl #(
  parameter bit HI_RES = 1'b1
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Pins
  input wire logic cs_n_i,
  // Configuration bits
  input wire logic channel_set_select_i,
  input wire logic auto_sequence_enable_i,
  input wire logic averaging_style_select_i,
  input wire logic [2:0] averaging_ratio_code_i,
  input wire logic resolution_boost_i,
  input wire logic soft_reset_i,
  // Converter core
  output logic conv_start_o,
  output logic conv_set_o,
  input wire logic conv_done_i,
  input wire logic [acso_pkg::SAMPLE_W-1:0] conv_data_i,
  // Result
  output logic result_valid_o,
  output logic [acso_pkg::OUT_W+acso_pkg::BOOST_BITS-1:0] result_o,
  output logic result_wide_o
);

  localparam int SW = acso_pkg::SAMPLE_W;
  localparam int OW = acso_pkg::OUT_W + acso_pkg::BOOST_BITS;
  localparam int AW = SW + 5;
  localparam int PACE = HI_RES ? acso_pkg::PACE_HI_RES_CYC : acso_pkg::PACE_LO_RES_CYC;

  initial begin
    if (PACE < 1) $error("pace count must be at least one cycle");
  end

  // ----------------------------------------------------------------------
  // Chip select edge
  // ----------------------------------------------------------------------
  logic cs_n_s;
  logic cs_n_prev_q;
  acso_sync u_cs_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .async_i(cs_n_i),
    .sync_o(cs_n_s)
  );

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cs_n_prev_q <= 1'b1;
    end else begin
      cs_n_prev_q <= cs_n_s;
    end
  end

  wire logic cs_fall = cs_n_prev_q & ~cs_n_s;
  wire logic clr = ~rst_n_i | soft_reset_i;

  // ----------------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------------
  wire logic code_nz = averaging_ratio_code_i != acso_pkg::RATIO_NONE;
  wire logic norm_ok = averaging_ratio_code_i <= acso_pkg::RATIO_MAX_NORMAL;
  wire logic roll_ok = averaging_ratio_code_i <= acso_pkg::RATIO_MAX_ROLLING;
  wire logic norm_mode = (averaging_style_select_i == acso_pkg::STYLE_NORMAL)
                         & code_nz & norm_ok;
  wire logic roll_mode = (averaging_style_select_i == acso_pkg::STYLE_ROLLING)
                         & code_nz & roll_ok;
  wire logic avg_on = norm_mode | roll_mode;
  wire logic [2:0] log2n = avg_on ? averaging_ratio_code_i : 3'h0;
  wire logic [5:0] ratio_n = 6'(7'h01 << log2n);

  // ----------------------------------------------------------------------
  // Channel set choice
  // ----------------------------------------------------------------------
  logic seq_next_q;
  wire logic set_sel = auto_sequence_enable_i ? seq_next_q
                                              : channel_set_select_i;

  // ----------------------------------------------------------------------
  // Conversion control
  // ----------------------------------------------------------------------
  typedef enum {ST_IDLE, ST_CONV, ST_PACE} acso_state_t;
  acso_state_t state_q;
  acso_state_t state_d;
  logic [5:0] taken_q;
  logic [7:0] pace_q;
  logic set_q;
  logic group_q;
  logic filled_q;
  logic [AW-1:0] acc_q;

  wire logic pace_done = pace_q == 8'(PACE - 1);
  wire logic group_last = (taken_q + 6'h01) >= ratio_n;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (cs_fall) begin
          state_d = ST_CONV;
        end
      end
      ST_CONV: begin
        if (conv_done_i) begin
          state_d = (group_q && !group_last) ? ST_PACE : ST_IDLE;
        end
      end
      ST_PACE: begin
        if (pace_done) begin
          state_d = ST_CONV;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  assign conv_start_o = (state_q == ST_IDLE && cs_fall) || (state_q == ST_PACE && pace_done);
  assign conv_set_o = set_q;

  always_ff @(posedge mclk_i) begin
    if (clr) begin
      state_q <= ST_IDLE;
      seq_next_q <= acso_pkg::SET_INDEX0;
      set_q <= acso_pkg::SET_INDEX0;
      group_q <= 1'b0;
      pace_q <= 8'h00;
    end else begin
      state_q <= state_d;
      pace_q <= (state_q == ST_PACE) ? pace_q + 8'h01 : 8'h00;
      if (state_q == ST_IDLE && cs_fall) begin
        set_q <= set_sel;
        group_q <= norm_mode;
        seq_next_q <= auto_sequence_enable_i ? ~seq_next_q : acso_pkg::SET_INDEX0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Normal averaging accumulator
  // ----------------------------------------------------------------------
  wire logic done = conv_done_i && state_q == ST_CONV;
  wire logic [AW-1:0] acc_sum = acc_q + AW'(conv_data_i);

  always_ff @(posedge mclk_i) begin
    if (clr) begin
      acc_q <= '0;
      taken_q <= 6'h00;
    end else if (done) begin
      if (group_q && !group_last) begin
        acc_q <= acc_sum;
        taken_q <= taken_q + 6'h01;
      end else begin
        acc_q <= '0;
        taken_q <= 6'h00;
      end
    end
  end

  // ----------------------------------------------------------------------
  // History and rolling sum
  // ----------------------------------------------------------------------
  logic [SW+2:0] hist_sum;
  acso_history #(
    .W(SW),
    .DEPTH(acso_pkg::HIST_DEPTH)
  ) u_hist (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .shift_i(done),
    .fill_i(done && !filled_q),
    .sample_i(conv_data_i),
    .log2n_i(roll_mode ? log2n[1:0] : 2'h0),
    .sum_o(hist_sum)
  );

  always_ff @(posedge mclk_i) begin
    if (clr) begin
      filled_q <= 1'b0;
    end else if (done) begin
      filled_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Output formatting
  // ----------------------------------------------------------------------
  wire logic boost = resolution_boost_i & avg_on;
  wire logic [AW+1:0] norm_total = {acc_sum, 2'b00};
  wire logic [AW+1:0] roll_total = {2'b00, hist_sum, 2'b00};
  wire logic [AW+1:0] pick = roll_mode ? roll_total : norm_total;
  wire logic [AW+1:0] shifted = pick >> log2n;
  wire logic [OW-1:0] fmt = boost ? OW'(shifted)
                                  : {2'b00, shifted[OW-1:2]};
  wire logic finish = done && !(group_q && !group_last);

  always_ff @(posedge mclk_i) begin
    if (clr) begin
      result_o <= '0;
      result_valid_o <= 1'b0;
      result_wide_o <= 1'b0;
    end else begin
      result_valid_o <= finish;
      if (finish) begin
        result_o <= fmt;
        result_wide_o <= boost;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_start_idle;
    state_q == ST_IDLE && cs_fall;
  endsequence

  a_seq_alternates: assert property (@(posedge mclk_i) disable iff (clr)
    (s_start_idle and auto_sequence_enable_i) |=> seq_next_q != $past(seq_next_q))
    else $error("sequencer did not alternate");
  a_manual_set: assert property (@(posedge mclk_i) disable iff (clr)
    (s_start_idle and !auto_sequence_enable_i) |=> set_q == $past(channel_set_select_i))
    else $error("manual channel set not applied");
  a_seq_ignores_manual: assert property (@(posedge mclk_i) disable iff (clr)
    (s_start_idle and auto_sequence_enable_i) |=> set_q == $past(seq_next_q))
    else $error("sequencer set not applied");
  a_pace_length: assert property (@(posedge mclk_i) disable iff (clr)
    (state_q == ST_CONV && state_d == ST_PACE) |-> ##(PACE) conv_start_o)
    else $error("paced start at wrong time");
  a_no_pin_start: assert property (@(posedge mclk_i) disable iff (clr)
    (state_q != ST_IDLE && cs_fall && !(state_q == ST_PACE && pace_done)) |-> !conv_start_o)
    else $error("chip select restarted a group");
  a_acc_cleared: assert property (@(posedge mclk_i) disable iff (clr)
    finish |=> acc_q == '0 && taken_q == 6'h00)
    else $error("accumulator not cleared after group");
  a_narrow_out: assert property (@(posedge mclk_i) disable iff (clr)
    (finish && !boost) |=> result_o[OW-1 -: 2] == 2'b00 && !result_wide_o)
    else $error("unboosted result too wide");
  a_roll_rate: assert property (@(posedge mclk_i) disable iff (clr)
    (done && roll_mode) |=> result_valid_o)
    else $error("rolling result missing");
  a_invalid_none: assert property (@(posedge mclk_i) disable iff (clr)
    (averaging_ratio_code_i > acso_pkg::RATIO_MAX_NORMAL) |-> !avg_on)
    else $error("invalid ratio code enabled averaging");
  a_roll_code_limit: assert property (@(posedge mclk_i) disable iff (clr)
    (averaging_style_select_i == acso_pkg::STYLE_ROLLING
      && averaging_ratio_code_i > acso_pkg::RATIO_MAX_ROLLING) |-> !avg_on)
    else $error("rolling mode accepted an invalid ratio code");

  // A group closes only once its full count of conversions has been taken.
  sequence s_group_close;
    done && group_q && group_last;
  endsequence

  a_group_count: assert property (@(posedge mclk_i) disable iff (clr)
    s_group_close |-> taken_q == ratio_n - 6'h01)
    else $error("group closed with wrong sample count");
  a_boost_wide: assert property (@(posedge mclk_i) disable iff (clr)
    (finish && boost) |=> result_wide_o)
    else $error("boosted result not flagged wide");
  a_valid_pulse: assert property (@(posedge mclk_i) disable iff (clr)
    result_valid_o |=> !result_valid_o)
    else $error("result valid held too long");
  a_start_pulse: assert property (@(posedge mclk_i) disable iff (clr)
    conv_start_o |=> !conv_start_o)
    else $error("conversion start held too long");
  a_seq_restart: assert property (@(posedge mclk_i) disable iff (clr)
    (s_start_idle and !auto_sequence_enable_i) |=> seq_next_q == acso_pkg::SET_INDEX0)
    else $error("sequencer did not restart at index 0");
  // Fill puts the same result in every entry, so the window sum is n times it.
  a_hist_fill: assert property (@(posedge mclk_i) disable iff (clr)
    (done && !filled_q) |-> hist_sum == ((SW+3)'(conv_data_i) << (roll_mode ? log2n : 3'h0)))
    else $error("history not filled on first conversion");

endmodule : acso_ctrl

// ### tb/acso_core_model.sv
// Purpose: Behavioural converter core facing the control block.
// Assumes: One conversion at a time, started by a one-cycle pulse.
// Notes: Samples come from a queue that the bench fills.
`timescale 1ns/1ns
module acso_core_model (
  // Clock
  input wire logic mclk_i,
  // Start from the block
  input wire logic start_i,
  // Result to the block
  output logic done_o,
  output logic [15:0] data_o
);
  logic [15:0] data_q [$];
  int wait_cnt;
  logic busy;

  initial begin
    done_o = 1'b0;
    data_o = 16'h0000;
    busy = 1'b0;
    wait_cnt = 0;
  end

  // Latency varies so prompt and slow answers both occur.
  // Stale data is inverted so nobody can rely on it outside done.
  always @(posedge mclk_i) begin
    done_o <= 1'b0;
    if (done_o) begin
      data_o <= ~data_o;
    end
    if (start_i && !busy) begin
      busy <= 1'b1;
      wait_cnt <= $urandom_range(24, 1);
    end else if (busy && wait_cnt == 1) begin
      busy <= 1'b0;
      done_o <= 1'b1;
      data_o <= (data_q.size() > 0) ? data_q.pop_front() : 16'h5A5A;
    end else if (busy) begin
      wait_cnt <= wait_cnt - 1;
    end
  end
endmodule : acso_core_model

// ### tb/acso_ctrl_test.sv
// Purpose: Self-checking bench for channel choice and averaging.
// Assumes: HI_RES left at its default.
// Notes: Expected results are queued by the driver, checked by the monitor.
`timescale 1ns/1ns
module acso_ctrl_test;
  typedef struct packed {
    logic [17:0] res;
    logic wide;
    logic set;
    logic [5:0] starts;
  } acso_exp_t;
  localparam int PACE = acso_pkg::PACE_HI_RES_CYC;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic cs_n = 1'b1;
  logic chs = 1'b0;
  logic seq = 1'b0;
  logic sty = 1'b0;
  logic [2:0] code = 3'h0;
  logic boost = 1'b0;
  logic srst = 1'b0;
  logic start, cset, done, rv, wide;
  logic [15:0] data;
  logic [17:0] res;
  acso_exp_t exp_q [$];
  acso_exp_t e;
  logic [15:0] hist [8];
  logic fill = 1'b1;
  logic ptr = 1'b0;
  int miscompares = 0;
  int cmp_count = 0;
  int res_cnt = 0;
  int starts = 0;
  int gap = 0;
  int cyc = 0;

  always #2 mclk = ~mclk;

  acso_ctrl u_acso_ctrl (.mclk_i(mclk), .rst_n_i(rst_n), .cs_n_i(cs_n),
    .channel_set_select_i(chs), .auto_sequence_enable_i(seq),
    .averaging_style_select_i(sty), .averaging_ratio_code_i(code),
    .resolution_boost_i(boost), .soft_reset_i(srst), .conv_start_o(start),
    .conv_set_o(cset), .conv_done_i(done), .conv_data_i(data),
    .result_valid_o(rv), .result_o(res), .result_wide_o(wide));
  acso_core_model u_acso_core_model (.mclk_i(mclk), .start_i(start), .done_o(done),
    .data_o(data));

  task automatic stop_test();
    $display("compares %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------------
  // Monitor
  // ----------------------------------------------------------------------
  always @(posedge mclk) begin
    cyc++;
    gap = done ? 0 : gap + 1;
    if (start && starts > 0) begin
      cmp_count++;
      if (gap != PACE && gap != PACE + 1) begin
        miscompares++;
        $display("[ERR] %0t paced start after %0d cycles", $time, gap);
      end
    end
    if (start) begin
      starts++;
    end
    if (rv) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : '1;
      cmp_count++;
      if ({res, wide, cset, starts[5:0]} !== e) begin
        miscompares++;
        $display("[ERR] %0t got %h/%b/%b/%0d exp %h", $time, res, wide, cset, starts, e);
      end
      starts = 0;
      res_cnt++;
    end
    if (cyc == 60000) begin
      miscompares++;
      $display("[ERR] %0t run too long", $time);
      stop_test();
    end
  end

  // ----------------------------------------------------------------------
  // Driver: style, ratio code, boost, sequencer, manual set
  // ----------------------------------------------------------------------
  task automatic conv(input logic s, input logic [2:0] c, input logic b, input logic q,
                      input logic h);
    logic [31:0] sum;
    logic [15:0] x;
    logic set;
    int k;
    int n;
    int r0;
    sum = 0;
    k = (c >= 3'h1 && c <= (s ? 3'h3 : 3'h5)) ? int'(c) : 0;
    n = (k > 0 && !s) ? 1 << k : 1;
    if (!q) begin
      ptr = 1'b0;
    end
    set = q ? ptr : h;
    ptr = q ? ~ptr : ptr;
    for (int i = 0; i < n; i++) begin
      x = 16'($urandom);
      u_acso_core_model.data_q.push_back(x);
      for (int j = 7; j > 0; j--) begin
        hist[j] = fill ? x : hist[j-1];
      end
      hist[0] = x;
      fill = 1'b0;
      sum += s ? 0 : x;
    end
    for (int i = 0; s && i < (1 << k); i++) begin
      sum += hist[i];
    end
    exp_q.push_back(k == 0 ? {2'h0, x, 1'h0, set, 6'h01} :
                    {b ? 18'((sum << 2) >> k) : 18'(sum >> k), b, set, 6'(n)});
    @(negedge mclk);
    sty = s;
    code = c;
    boost = b;
    seq = q;
    chs = h;
    repeat (4) @(negedge mclk);
    r0 = res_cnt;
    cs_n = 1'b0;
    repeat (16) @(negedge mclk);
    cs_n = 1'b1;
    repeat (8) @(negedge mclk);
    cs_n = !(n > 1);
    repeat (8) @(negedge mclk);
    cs_n = 1'b1;
    for (int t = 0; t < 6000 && res_cnt == r0; t++) begin
      @(negedge mclk);
    end
    repeat (130) @(negedge mclk);
  endtask : conv

  initial begin
    void'($urandom(32'h82C78C95));
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    conv(1'b0, 3'h0, 1'b0, 1'b0, 1'b0);
    conv(1'b0, 3'h0, 1'b0, 1'b0, 1'b1);
    $display("test manual set done");
    for (int i = 0; i < 5; i++) begin
      conv(1'b0, 3'h0, 1'b0, 1'b1, 1'($urandom));
    end
    conv(1'b0, 3'h0, 1'b1, 1'b0, 1'b1);
    $display("test sequencer done");
    for (int i = 0; i < 16; i++) begin
      conv(1'b0, i[2:0], i[3], 1'b0, 1'b0);
    end
    $display("test normal averaging done");
    for (int i = 0; i < 16; i++) begin
      conv(1'b1, i[2:0], 1'($urandom), 1'b0, 1'b0);
    end
    $display("test rolling averaging done");
    srst = 1'b1;
    repeat (2) @(negedge mclk);
    srst = 1'b0;
    fill = 1'b1;
    ptr = 1'b0;
    repeat (4) @(negedge mclk);
    conv(1'b1, 3'h3, 1'b0, 1'b0, 1'b0);
    conv(1'b1, 3'h3, 1'b1, 1'b0, 1'b0);
    $display("test history refill done");
    repeat (10) @(negedge mclk);
    cmp_count++;
    if (exp_q.size() != 0) begin
      miscompares++;
      $display("[ERR] %0t %0d results missing", $time, exp_q.size());
    end
    stop_test();
  end
endmodule : acso_ctrl_test
